// File: logic/nvm_regs_params.svh
// Purpose: addresses, field positions, reset values and timing counts
// Assumes: 250 MHz system clock, 16-bit registers on a byte address
// Notes:   definitions only, no logic
`ifndef NVM_REGS_PARAMS_SVH
`define NVM_REGS_PARAMS_SVH

// register addresses
`define ADDR_UNLOCK         8'h04
`define ADDR_SCRATCH_ONE    8'h05
`define ADDR_SCRATCH_TWO    8'h06
`define ADDR_OFFSET         8'h07
`define ADDR_SCRATCH_THREE  8'h08
`define ADDR_PART_ID        8'h0f

// field positions
`define UNLOCK_BIT          15
`define BUSY_BIT            14
`define REV_MSB             15
`define REV_LSB             12
`define PART_MSB            11
`define PART_LSB            0

// reset values and clamp limits
`define UNLOCK_RESET        1'b0
`define OFFSET_RESET        16'h0000
`define SCRATCH_RESET       16'h0000
`define TEMP_MAX            16'h7fff
`define TEMP_MIN            16'h8000

// timing: least times, rounded up to whole cycles
`define CLK_PERIOD_NS       4
`define NVM_PROG_TIME_NS    7000000
`define NVM_LOAD_TIME_NS    1000
`define NVM_PROG_CYCLES \
    ((`NVM_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NVM_LOAD_CYCLES \
    ((`NVM_LOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: logic/nvm_regs_pkg.sv
// Purpose: shared types of the scratch, offset and id register bank
// Assumes: nothing beyond the params header
// Notes:   numbers live in the header, types live here
package nvm_regs_pkg;

    // life cycle of the non-volatile store
    typedef enum logic [1:0] {
        NVM_LOAD,
        NVM_IDLE,
        NVM_PROG
    } nvm_state_t;

    typedef logic [15:0] reg_word_t;
    typedef logic [1:0]  scratch_idx_t;

endpackage

// File: logic/nvm_word_store.sv
// Purpose: three non-volatile scratch words with load and program timing
// Assumes: one program request at a time, only taken while idle
// Notes:   the array has no reset, it models cells that keep their data
`timescale 1ns/1ns
`include "nvm_regs_params.svh"

module nvm_word_store
    import nvm_regs_pkg::*;
#(
    parameter int        PROG_CYCLES = `NVM_PROG_CYCLES,
    parameter reg_word_t FACTORY_ONE = 16'h1234,
    parameter reg_word_t FACTORY_TWO = 16'h5678,
    parameter reg_word_t FACTORY_THREE = 16'h9abc
) (
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_sys_rst,
    // program request
    input  wire logic         i_prog_req,
    input  wire scratch_idx_t i_prog_idx,
    input  wire reg_word_t    i_prog_data,
    // status and load
    output logic              o_busy,
    output logic              o_loading,
    output logic              o_load_done,
    output reg_word_t         o_word_one,
    output reg_word_t         o_word_two,
    output reg_word_t         o_word_three
);

    localparam int CNT_W = 24;

    // no reset reaches the cells; they keep data across every reset
    reg_word_t    cells [3] = '{FACTORY_ONE, FACTORY_TWO, FACTORY_THREE};
    nvm_state_t   state;
    logic [CNT_W-1:0] count;
    scratch_idx_t prog_idx;
    reg_word_t    prog_data;

    // sequencer: load after every reset, then serve program requests
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state       <= NVM_LOAD;
            count       <= '0;
            o_load_done <= 1'b0;
            prog_idx    <= '0;
            prog_data   <= '0;
        end else begin
            o_load_done <= 1'b0;
            case (state)
                NVM_LOAD: begin
                    if (count == CNT_W'(`NVM_LOAD_CYCLES - 1)) begin
                        state       <= NVM_IDLE;
                        count       <= '0;
                        o_load_done <= 1'b1;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                NVM_IDLE: begin
                    if (i_prog_req) begin
                        state     <= NVM_PROG;
                        count     <= '0;
                        prog_idx  <= i_prog_idx;
                        prog_data <= i_prog_data;
                    end
                end
                NVM_PROG: begin
                    if (count == CNT_W'(PROG_CYCLES - 1)) begin
                        state <= NVM_IDLE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                default: state <= NVM_IDLE;
            endcase
        end
    end

    // the cell is committed at the end of the program time
    always_ff @(posedge i_sys_clk) begin
        if (!i_sys_rst && state == NVM_PROG &&
            count == CNT_W'(PROG_CYCLES - 1)) begin
            cells[prog_idx] <= prog_data;
        end
    end

    assign o_busy       = (state != NVM_IDLE);
    assign o_loading    = (state == NVM_LOAD);
    assign o_word_one   = cells[0];
    assign o_word_two   = cells[1];
    assign o_word_three = cells[2];

endmodule

// File: logic/offset_saturate.sv
// Purpose: add the calibration offset to a linearised temperature
// Assumes: both operands two's complement, 7.8125 mdegC per lsb
// Notes:   purely combinational, caller registers the result
`timescale 1ns/1ns
`include "nvm_regs_params.svh"

module offset_saturate
    import nvm_regs_pkg::*;
(
    // operands
    input  wire reg_word_t i_temp,
    input  wire reg_word_t i_offset,
    // result
    output reg_word_t      o_sum
);

    logic [16:0] wide;

    // one extra bit shows overflow; clamp rather than wrap
    always_comb begin
        wide = {i_temp[15], i_temp} + {i_offset[15], i_offset};
        if (wide[16] == wide[15]) begin
            o_sum = wide[15:0];
        end else if (wide[16]) begin
            o_sum = `TEMP_MIN;
        end else begin
            o_sum = `TEMP_MAX;
        end
    end

endmodule

// File: logic/scratch_offset_id_regs.sv
// Purpose: scratch words, temperature offset, unlock and id registers
// Assumes: serial front end delivers one-cycle read and write strobes
// Notes:   read data answers one cycle after the read strobe
`timescale 1ns/1ns
`include "nvm_regs_params.svh"

// Summary of operation
// - three scratch words at 05h, 06h, 08h
// - locked writes change only the volatile copy
// - unlocked scratch write programs its cell when not busy
// - cells hold factory id, still writable
// - offset at 07h added, resets zero
// - offset two's complement, temperature format
// - overflowing sum saturates, never wraps
// - read-only id: revision and part code
// - unlock bit 15 selects program target
// - busy bit 14 during program or load
module scratch_offset_id_regs
    import nvm_regs_pkg::*;
#(
    parameter int        PROG_CYCLES = `NVM_PROG_CYCLES,
    parameter logic [3:0]  REV_CODE  = 4'h5,   // arbitrary value
    parameter logic [11:0] PART_CODE = 12'h0a5 // arbitrary value
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    // register access from the serial front end
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire reg_word_t   i_reg_wdata,
    input  wire logic        i_reg_rd,
    output reg_word_t        o_reg_rdata,
    output logic             o_reg_rvalid,
    // temperature path
    input  wire reg_word_t   i_temp_lin,
    input  wire logic        i_temp_valid,
    output reg_word_t        o_temp_result,
    output logic             o_temp_valid
);

    reg_word_t    scratch [3];
    reg_word_t    temp_offset;
    logic         nvm_unlock_bit;
    logic         nvm_busy;
    logic         nvm_loading;
    logic         load_done;
    reg_word_t    nvm_one;
    reg_word_t    nvm_two;
    reg_word_t    nvm_three;
    logic         prog_req;
    scratch_idx_t prog_idx;
    logic [2:0]   scratch_sel;
    logic         scratch_hit;
    reg_word_t    sat_sum;
    reg_word_t    next_rdata;

    // scratch address to word index; hit flag in the top bit
    function automatic logic [2:0] scratch_lookup(input logic [7:0] addr);
        if (addr == `ADDR_SCRATCH_ONE) begin
            scratch_lookup = 3'b100;
        end else if (addr == `ADDR_SCRATCH_TWO) begin
            scratch_lookup = 3'b101;
        end else if (addr == `ADDR_SCRATCH_THREE) begin
            scratch_lookup = 3'b110;
        end else begin
            scratch_lookup = 3'b000;
        end
    endfunction

    // decoded once, then split into hit flag and word index
    assign scratch_sel = scratch_lookup(i_reg_addr);
    assign scratch_hit = scratch_sel[2];
    assign prog_idx    = scratch_sel[1:0];

    // a request made while busy is dropped; the host polls busy first
    assign prog_req = i_reg_wr && scratch_hit && nvm_unlock_bit
                      && !nvm_busy;

    nvm_word_store #(
        .PROG_CYCLES   (PROG_CYCLES)
    ) u_store (
        .i_sys_clk     (i_sys_clk),
        .i_sys_rst     (i_sys_rst),
        .i_prog_req    (prog_req),
        .i_prog_idx    (prog_idx),
        .i_prog_data   (i_reg_wdata),
        .o_busy        (nvm_busy),
        .o_loading     (nvm_loading),
        .o_load_done   (load_done),
        .o_word_one    (nvm_one),
        .o_word_two    (nvm_two),
        .o_word_three  (nvm_three)
    );

    offset_saturate u_sat (
        .i_temp        (i_temp_lin),
        .i_offset      (temp_offset),
        .o_sum         (sat_sum)
    );

    // scratch words: loaded from the cells, then written by the host
    // writes inside the load window are dropped; the copy would bury them
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scratch[0] <= `SCRATCH_RESET;
            scratch[1] <= `SCRATCH_RESET;
            scratch[2] <= `SCRATCH_RESET;
        end else if (load_done) begin
            scratch[0] <= nvm_one;
            scratch[1] <= nvm_two;
            scratch[2] <= nvm_three;
        end else if (i_reg_wr && scratch_hit && !nvm_loading) begin
            // volatile copy follows the write, locked or not
            scratch[prog_idx] <= i_reg_wdata;
        end
    end

    // offset and unlock registers
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            temp_offset    <= `OFFSET_RESET;
            nvm_unlock_bit <= `UNLOCK_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `ADDR_OFFSET) begin
                temp_offset <= i_reg_wdata;
            end else if (i_reg_addr == `ADDR_UNLOCK) begin
                nvm_unlock_bit <= i_reg_wdata[`UNLOCK_BIT];
            end
        end
    end

    // read mux; unmapped and reserved bits read as zero
    always_comb begin
        next_rdata = '0;
        if (i_reg_addr == `ADDR_UNLOCK) begin
            next_rdata[`UNLOCK_BIT] = nvm_unlock_bit;
            next_rdata[`BUSY_BIT]   = nvm_busy;
        end else if (scratch_hit) begin
            next_rdata = scratch[prog_idx];
        end else if (i_reg_addr == `ADDR_OFFSET) begin
            next_rdata = temp_offset;
        end else if (i_reg_addr == `ADDR_PART_ID) begin
            next_rdata = {REV_CODE, PART_CODE};
        end
    end

    // read answer registered so the port comes from a flop
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata  <= '0;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // temperature result with offset, one cycle of latency
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_temp_result <= '0;
            o_temp_valid  <= 1'b0;
        end else begin
            o_temp_valid <= i_temp_valid;
            if (i_temp_valid) begin
                o_temp_result <= sat_sum;
            end
        end
    end

    // ---- checks ----
    // all checks share the one clock and stay quiet in reset
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic [16:0] chk_sum;
    assign chk_sum = {i_temp_lin[15], i_temp_lin}
                   + {temp_offset[15], temp_offset};

    property p_scratch_store;
        i_reg_wr && scratch_hit && !nvm_loading && !load_done
            |=> scratch[$past(prog_idx)] == $past(i_reg_wdata);
    endproperty
    a_scratch_store: assert property (p_scratch_store)
        else $error("scratch word not stored");

    property p_locked_no_prog;
        i_reg_wr && scratch_hit && !nvm_unlock_bit
            |-> !prog_req ##1 !(nvm_busy && !nvm_loading && !$past(nvm_busy));
    endproperty
    a_locked_no_prog: assert property (p_locked_no_prog)
        else $error("locked write started programming");

    property p_unlocked_prog;
        i_reg_wr && scratch_hit && nvm_unlock_bit && !nvm_busy
            |=> nvm_busy [*2];
    endproperty
    a_unlocked_prog: assert property (p_unlocked_prog)
        else $error("unlocked write did not program");

    property p_load_copies;
        load_done |=> scratch[0] == $past(nvm_one)
                   && scratch[1] == $past(nvm_two)
                   && scratch[2] == $past(nvm_three);
    endproperty
    a_load_copies: assert property (p_load_copies)
        else $error("scratch not loaded from cells");

    property p_offset_add;
        i_temp_valid && (chk_sum[16] == chk_sum[15])
            |=> o_temp_valid && o_temp_result == $past(chk_sum[15:0]);
    endproperty
    a_offset_add: assert property (p_offset_add)
        else $error("offset not added to result");

    property p_offset_write;
        i_reg_wr && i_reg_addr == `ADDR_OFFSET
            ##1 !i_reg_wr
            ##1 i_reg_rd && i_reg_addr == `ADDR_OFFSET && !i_reg_wr
            |=> o_reg_rdata == $past(i_reg_wdata, 3);
    endproperty
    a_offset_write: assert property (p_offset_write)
        else $error("offset readback differs");

    property p_sat_high;
        i_temp_valid && !chk_sum[16] && chk_sum[15]
            |=> o_temp_result == `TEMP_MAX;
    endproperty
    a_sat_high: assert property (p_sat_high)
        else $error("positive overflow not clamped");

    property p_sat_low;
        i_temp_valid && chk_sum[16] && !chk_sum[15]
            |=> o_temp_result == `TEMP_MIN;
    endproperty
    a_sat_low: assert property (p_sat_low)
        else $error("negative overflow not clamped");

    property p_id_read;
        i_reg_rd && i_reg_addr == `ADDR_PART_ID
            |=> o_reg_rvalid && o_reg_rdata == {REV_CODE, PART_CODE};
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("id register wrong");

    property p_unlock_read;
        i_reg_rd && i_reg_addr == `ADDR_UNLOCK
            |=> o_reg_rdata[`UNLOCK_BIT] == $past(nvm_unlock_bit)
             && o_reg_rdata[13:0] == 14'h0000;
    endproperty
    a_unlock_read: assert property (p_unlock_read)
        else $error("unlock register readback wrong");

    property p_busy_read;
        i_reg_rd && i_reg_addr == `ADDR_UNLOCK
            |=> o_reg_rdata[`BUSY_BIT] == $past(nvm_busy);
    endproperty
    a_busy_read: assert property (p_busy_read)
        else $error("busy flag readback wrong");

    property p_busy_load;
        load_done |-> !nvm_busy && $past(nvm_busy);
    endproperty
    a_busy_load: assert property (p_busy_load)
        else $error("busy not covering load");

    // guards on the lock, the load window and the read decode
    property p_locked_cells_kept;
        i_reg_wr && scratch_hit && !nvm_unlock_bit && !nvm_busy
            |=> $stable(nvm_one) && $stable(nvm_two) && $stable(nvm_three);
    endproperty
    a_locked_cells_kept: assert property (p_locked_cells_kept)
        else $error("locked write changed a cell");

    property p_load_blocks_write;
        nvm_loading |=> scratch[0] == $past(scratch[0])
                     && scratch[1] == $past(scratch[1])
                     && scratch[2] == $past(scratch[2]);
    endproperty
    a_load_blocks_write: assert property (p_load_blocks_write)
        else $error("scratch word changed during load");

    property p_unmapped_zero;
        i_reg_rd && !scratch_hit && i_reg_addr != `ADDR_UNLOCK
            && i_reg_addr != `ADDR_OFFSET && i_reg_addr != `ADDR_PART_ID
            |=> o_reg_rdata == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped address read not zero");

    c_load: cover property (load_done);
    c_prog: cover property (prog_req ##1 nvm_busy);
    c_sat:  cover property (i_temp_valid && chk_sum[16] != chk_sum[15]);
    c_id:   cover property (i_reg_rd && i_reg_addr == `ADDR_PART_ID);
    c_lock: cover property (i_reg_wr && scratch_hit && !nvm_unlock_bit);

endmodule

// File: testbench/host_model.sv
// Purpose: host side of the register strobes, stands in for the serial master
// Assumes: one access at a time, driven just after the rising edge
// Notes:   each access ends on a spare edge so two strobes never collide
`timescale 1ns/1ns
`include "nvm_regs_params.svh"

module host_model
    import nvm_regs_pkg::*;
(
    // clock
    input  wire logic      i_sys_clk,
    // register strobes toward the device
    output logic [7:0]     o_reg_addr,
    output logic           o_reg_wr,
    output reg_word_t      o_reg_wdata,
    output logic           o_reg_rd,
    // read answer
    input  wire reg_word_t i_reg_rdata,
    input  wire logic      i_reg_rvalid
);
    // idle bus at time zero
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_wdata = 16'h0000;
        o_reg_rd    = 1'b0;
    end

    // one write; released lines show the inverse, never the old value
    task automatic wr(input logic [7:0] a, input reg_word_t d);
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        o_reg_wr    <= 1'b1;
        @(posedge i_sys_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
        @(posedge i_sys_clk);
    endtask

    // one read; the answer is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output reg_word_t d,
                      output logic v);
        o_reg_addr <= a;
        o_reg_rd   <= 1'b1;
        @(posedge i_sys_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
        @(posedge i_sys_clk);
        d = i_reg_rdata;
        v = i_reg_rvalid;
    endtask

    // poll the busy flag, bounded so a stuck flag cannot hang the host
    task automatic wait_ready(output logic ok);
        reg_word_t s;
        logic      v;
        ok = 1'b0;
        for (int n = 0; n < 200 && !ok; n++) begin
            rd(`ADDR_UNLOCK, s, v);
            ok = (v === 1'b1) && (s[`BUSY_BIT] === 1'b0);
        end
    endtask

    // program a cell; the first word keeps its traceability data
    task automatic prog(input logic [7:0] a, input reg_word_t d,
                        output logic ok);
        wait_ready(ok);
        if (ok && a != `ADDR_SCRATCH_ONE) begin
            wr(a, d);
        end
    endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: self-checking bench of the scratch, offset and id registers
// Assumes: short program time through PROG_CYCLES, fixed random seed
// Notes:   cell contents are judged after a reset reloads them
`timescale 1ns/1ns
`include "nvm_regs_params.svh"

module tb_top
    import nvm_regs_pkg::*;
;
    localparam logic [3:0]  REV   = 4'h5;   // arbitrary value
    localparam logic [11:0] PART  = 12'h0a5; // arbitrary value
    localparam int          LIMIT = 20000;
    localparam reg_word_t   CT [4] = '{16'h7ff0, 16'h8010, 16'h1234, 16'h7fff};
    localparam reg_word_t   CO [4] = '{16'h0020, 16'hffc0, 16'h0000, 16'h8000};

    logic        i_sys_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic        reg_rvalid;
    logic        temp_valid = 1'b0;
    logic        temp_v;
    reg_word_t   reg_wdata;
    reg_word_t   reg_rdata;
    reg_word_t   temp_lin = 16'h0000;
    reg_word_t   temp_res;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    integer      seed = 32'h7288de9a;

    // 250 MHz clock
    always #2 i_sys_clk = ~i_sys_clk;

    scratch_offset_id_regs #(
        .PROG_CYCLES (20),
        .REV_CODE    (REV),
        .PART_CODE   (PART)
    ) i_scratch_offset_id_regs (
        .i_sys_clk     (i_sys_clk),
        .i_sys_rst     (i_sys_rst),
        .i_reg_addr    (reg_addr),
        .i_reg_wr      (reg_wr),
        .i_reg_wdata   (reg_wdata),
        .i_reg_rd      (reg_rd),
        .o_reg_rdata   (reg_rdata),
        .o_reg_rvalid  (reg_rvalid),
        .i_temp_lin    (temp_lin),
        .i_temp_valid  (temp_valid),
        .o_temp_result (temp_res),
        .o_temp_valid  (temp_v)
    );

    host_model i_host_model (
        .i_sys_clk    (i_sys_clk),
        .o_reg_addr   (reg_addr),
        .o_reg_wr     (reg_wr),
        .o_reg_wdata  (reg_wdata),
        .o_reg_rd     (reg_rd),
        .i_reg_rdata  (reg_rdata),
        .i_reg_rvalid (reg_rvalid)
    );

    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch and still reaches the report
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input string name, input reg_word_t seen,
                       input reg_word_t exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // read and compare; a missing valid pulse turns the data unknown
    task automatic rdc(input string name, input logic [7:0] a,
                       input reg_word_t exp);
        reg_word_t d;
        logic      v;
        i_host_model.rd(a, d, v);
        chk(name, (v === 1'b1) ? d : 16'hxxxx, exp);
    endtask

    // expected sum, clamped when the sign bit would wrap
    function automatic reg_word_t sat(input reg_word_t t, input reg_word_t o);
        logic [16:0] s;
        s = {t[15], t} + {o[15], o};
        if (s[16] != s[15]) begin
            return s[16] ? 16'h8000 : 16'h7fff;
        end
        return s[15:0];
    endfunction

    task automatic tchk(input reg_word_t t, input reg_word_t o);
        temp_lin   <= t;
        temp_valid <= 1'b1;
        @(posedge i_sys_clk);
        temp_valid <= 1'b0;
        temp_lin   <= ~t;
        @(posedge i_sys_clk);
        chk("temperature", (temp_v === 1'b1) ? temp_res : 16'hxxxx,
            sat(t, o));
    endtask

    // reset, then the busy flag must cover the load and then clear
    task automatic do_reset;
        logic ok;
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        rdc("unlock during load", `ADDR_UNLOCK, 16'h4000);
        // a scratch write inside the load window must leave no trace
        i_host_model.wr(`ADDR_SCRATCH_THREE, 16'h0bad);
        i_host_model.wait_ready(ok);
        chk("load finished", {15'h0000, ok}, 16'h0001);
    endtask

    initial begin
        reg_word_t v2;
        reg_word_t v3;
        reg_word_t t;
        reg_word_t o;
        logic      ok;
        v2 = reg_word_t'($random(seed));
        v3 = reg_word_t'($random(seed));
        // factory contents, id, reserved places
        do_reset();
        rdc("scratch one", `ADDR_SCRATCH_ONE, 16'h1234);
        rdc("scratch two", `ADDR_SCRATCH_TWO, 16'h5678);
        rdc("scratch three", `ADDR_SCRATCH_THREE, 16'h9abc);
        rdc("offset reset", `ADDR_OFFSET, 16'h0000);
        rdc("id", `ADDR_PART_ID, {REV, PART});
        i_host_model.wr(`ADDR_PART_ID, 16'hffff);
        rdc("id after write", `ADDR_PART_ID, {REV, PART});
        rdc("unmapped 09", 8'h09, 16'h0000);
        rdc("unmapped 03", 8'h03, 16'h0000);
        $display("test 1 done");
        // locked writes reach only the volatile copies
        i_host_model.wr(`ADDR_UNLOCK, 16'h0000);
        rdc("unlock locked", `ADDR_UNLOCK, 16'h0000);
        i_host_model.wr(`ADDR_SCRATCH_ONE, v2);
        i_host_model.wr(`ADDR_SCRATCH_TWO, v3);
        i_host_model.wr(`ADDR_SCRATCH_THREE, ~v2);
        rdc("locked one", `ADDR_SCRATCH_ONE, v2);
        rdc("locked two", `ADDR_SCRATCH_TWO, v3);
        rdc("locked three", `ADDR_SCRATCH_THREE, ~v2);
        do_reset();
        rdc("cell one kept", `ADDR_SCRATCH_ONE, 16'h1234);
        rdc("cell two kept", `ADDR_SCRATCH_TWO, 16'h5678);
        rdc("cell three kept", `ADDR_SCRATCH_THREE, 16'h9abc);
        $display("test 2 done");
        // unlocked write programs; a second one while busy is dropped
        i_host_model.wr(`ADDR_UNLOCK, 16'hffff);
        rdc("unlock set", `ADDR_UNLOCK, 16'h8000);
        i_host_model.prog(`ADDR_SCRATCH_TWO, v3, ok);
        rdc("unlock busy", `ADDR_UNLOCK, 16'hc000);
        i_host_model.wr(`ADDR_SCRATCH_THREE, v2);
        rdc("volatile two", `ADDR_SCRATCH_TWO, v3);
        rdc("volatile three", `ADDR_SCRATCH_THREE, v2);
        i_host_model.wait_ready(ok);
        rdc("unlock idle", `ADDR_UNLOCK, 16'h8000);
        do_reset();
        rdc("cell two programmed", `ADDR_SCRATCH_TWO, v3);
        rdc("cell three dropped", `ADDR_SCRATCH_THREE, 16'h9abc);
        rdc("cell one intact", `ADDR_SCRATCH_ONE, 16'h1234);
        $display("test 3 done");
        // offset added with clamping, corners first then random
        for (int k = 0; k < 28; k++) begin
            t = (k < 4) ? CT[k] : reg_word_t'($random(seed));
            o = (k < 4) ? CO[k] : reg_word_t'($random(seed));
            i_host_model.wr(`ADDR_OFFSET, o);
            rdc("offset written", `ADDR_OFFSET, o);
            tchk(t, o);
        end
        rdc("offset readback", `ADDR_OFFSET, o);
        $display("test 4 done");
        summarize();
    end
endmodule
